// *** src/pllc_ctrl.v ***
// Function
// R01 - The loop reference is oscillator and clock pin combined; one is quiet.
// R02 - After reset the loop is bypassed until loop enable is written to 1.
// R03 - Multiplier and all dividers get allowed values before loop enable.
// R04 - Loop reset is held asserted at least 125 ns during initialization.
// R05 - Enable waits 187.5 us of lock after pre-divider or multiplier change.
// R06 - The reference after the pre-divider stays between 12 MHz and 50 MHz.
// R07 - Multiplier resets to 13; only 4 through 25 is programmed.
// R08 - Loop output before the system dividers is 140 MHz to 600 MHz.
// R09 - The device makes four clocks, each with its own divider.
// R10 - Dividers reset to core by 1, peripheral by 2, memory interface by 3.
// R11 - The peripheral clock is one half, third or quarter of the core clock.
// R12 - All three alignment bits 2:0 are set to 1.
// R13 - Every system divider change is followed by a go command write.
// R14 - A loop change affecting system dividers is followed by a bridge reset.
// R15 - A loop output near the maximum is preferred for lower jitter.
// R16 - The device loads new ratios together at an aligned boundary on go.
`include "pllc_map.vh"
module pllc_ctrl #(
   parameter [31:0] LOCK_CYCLES = `PLLC_LOCK_CYCLES
) (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        ce,
   input  wire        start,
   input  wire [15:0] cfg_ref_khz,
   input  wire [4:0]  cfg_pre_div,
   input  wire [4:0]  cfg_mult,
   input  wire [4:0]  cfg_core_div,
   input  wire [4:0]  cfg_peri_div,
   input  wire [4:0]  cfg_mem_div,
   output wire        busy,
   output reg         done,
   output reg         cfg_error,
   output reg  [2:0]  error_code,
   output reg         loop_enabled,
   output wire [31:0] reg_addr,
   output wire [31:0] reg_wdata,
   output wire        reg_wr,
   output wire        reg_rd,
   input  wire [31:0] reg_rdata,
   input  wire        reg_ack
);
   // =======================================================
   // States
   localparam [4:0] S_IDLE      = 5'h00;
   localparam [4:0] S_CHECK     = 5'h01;
   localparam [4:0] S_BYPASS    = 5'h02;
   localparam [4:0] S_MULT      = 5'h03;
   localparam [4:0] S_DIV0      = 5'h04;
   localparam [4:0] S_DIV1      = 5'h05;
   localparam [4:0] S_DIV2      = 5'h06;
   localparam [4:0] S_DIV3      = 5'h07;
   localparam [4:0] S_RST_WAIT  = 5'h08;
   localparam [4:0] S_RELEASE   = 5'h09;
   localparam [4:0] S_LOCK_WAIT = 5'h0a;
   localparam [4:0] S_ALIGN     = 5'h0b;
   localparam [4:0] S_GO        = 5'h0c;
   localparam [4:0] S_GO_POLL   = 5'h0d;
   localparam [4:0] S_BR_ON     = 5'h0e;
   localparam [4:0] S_BR_OFF    = 5'h0f;
   localparam [4:0] S_ENABLE    = 5'h10;

   localparam [2:0] ERR_NONE  = 3'h0;
   localparam [2:0] ERR_MULT  = 3'h1;
   localparam [2:0] ERR_REF   = 3'h2;
   localparam [2:0] ERR_OUT   = 3'h3;
   localparam [2:0] ERR_RATIO = 3'h4;
   localparam [2:0] ERR_DIV   = 3'h5;

   localparam [31:0] RST_CYCLES = `PLLC_RST_CYCLES;

   // =======================================================
   // Registers
   reg  [4:0]  state_reg;
   reg  [4:0]  state_next;
   reg         acc_pend_reg;
   reg  [15:0] ref_reg;
   reg  [4:0]  pre_reg;
   reg  [4:0]  mult_reg;
   reg  [4:0]  core_reg;
   reg  [4:0]  peri_reg;
   reg  [4:0]  mem_reg;

   reg         acc_state;
   reg         acc_wr;
   reg  [31:0] acc_addr;
   reg  [31:0] acc_wdata;
   reg         tmr_load;
   reg  [31:0] tmr_value;
   reg  [2:0]  check_err;

   wire        acc_req;
   wire        acc_done;
   wire [31:0] acc_rdata;
   wire        tmr_expired;

   // =======================================================
   // Range checks
   wire [31:0] ref_w   = {16'h0000, ref_reg};
   wire [31:0] pre_w   = {27'h0000000, pre_reg};
   wire [31:0] ref_mul = ref_w * {27'h0000000, mult_reg};
   wire [6:0]  core_x2 = {1'b0, core_reg, 1'b0};
   wire [6:0]  core_x3 = {2'b00, core_reg} + {1'b0, core_reg, 1'b0};
   wire [6:0]  core_x4 = {core_reg, 2'b00};
   wire [6:0]  peri_w  = {2'b00, peri_reg};

   always @* begin
      check_err = ERR_NONE;
      if (pre_reg == 5'h00 || core_reg == 5'h00 ||
          peri_reg == 5'h00 || mem_reg == 5'h00) begin
         check_err = ERR_DIV;
      end else if (mult_reg < `PLLC_MULT_MIN ||
                   mult_reg > `PLLC_MULT_MAX) begin
         check_err = ERR_MULT; // [R07]
      end else if (ref_w < `PLLC_REF_MIN_KHZ * pre_w ||
                   ref_w > `PLLC_REF_MAX_KHZ * pre_w) begin
         check_err = ERR_REF; // [R06]
      end else if (ref_mul < `PLLC_OUT_MIN_KHZ * pre_w ||
                   ref_mul > `PLLC_OUT_MAX_KHZ * pre_w) begin
         check_err = ERR_OUT; // [R08]
      end else if (peri_w != core_x2 && peri_w != core_x3 &&
                   peri_w != core_x4) begin
         check_err = ERR_RATIO; // [R11]
      end
   end

   // =======================================================
   // Access selection per state
   function [31:0] div_word;
      input [4:0] ratio;
      begin
         div_word = 32'h0000_0000;
         div_word[`PLLC_DIV_EN_BIT] = 1'b1;
         div_word[4:0] = ratio - 5'h01;
      end
   endfunction

   always @* begin
      acc_state = 1'b1;
      acc_wr    = 1'b1;
      acc_addr  = `PLLC_BASE_ADDR + `PLLC_CSR_OFS;
      acc_wdata = 32'h0000_0000;
      case (state_reg)
         S_BYPASS: acc_wdata[`PLLC_CSR_RST_BIT] = 1'b1; // [R02] [R04]
         S_MULT: begin
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_MULT_OFS;
            acc_wdata = {27'h0000000, mult_reg - 5'h01}; // [R03] [R07]
         end
         S_DIV0: begin
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_DIV0_OFS;
            acc_wdata = div_word(pre_reg); // [R03] [R09]
         end
         S_DIV1: begin
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_DIV1_OFS;
            acc_wdata = div_word(core_reg); // [R03]
         end
         S_DIV2: begin
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_DIV2_OFS;
            acc_wdata = div_word(peri_reg); // [R03]
         end
         S_DIV3: begin
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_DIV3_OFS;
            acc_wdata = div_word(mem_reg); // [R03]
         end
         S_RELEASE: acc_wdata = 32'h0000_0000;
         S_ALIGN: begin
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_ALIGN_OFS;
            acc_wdata = `PLLC_ALIGN_ALL; // [R12]
         end
         S_GO: begin
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_CMD_OFS;
            acc_wdata[`PLLC_CMD_GO_BIT] = 1'b1; // [R13] [R16]
         end
         S_GO_POLL: begin
            acc_wr    = 1'b0;
            acc_addr  = `PLLC_BASE_ADDR + `PLLC_STAT_OFS;
         end
         S_BR_ON: begin
            acc_addr  = `PLLC_BRIDGE_ADDR;
            acc_wdata[`PLLC_BRIDGE_RST_BIT] = 1'b1; // [R14]
         end
         S_BR_OFF: acc_addr = `PLLC_BRIDGE_ADDR;
         S_ENABLE: acc_wdata[`PLLC_CSR_EN_BIT] = 1'b1; // [R02]
         default: begin
            acc_state = 1'b0;
         end
      endcase
   end

   assign acc_req = acc_state && !acc_pend_reg;
   assign busy    = (state_reg != S_IDLE);

   // =======================================================
   // Sequencer
   always @* begin
      state_next = state_reg;
      tmr_load   = 1'b0;
      tmr_value  = RST_CYCLES;
      case (state_reg)
         S_IDLE: begin
            if (start) begin
               state_next = S_CHECK;
            end
         end
         S_CHECK: begin
            state_next = (check_err != ERR_NONE) ? S_IDLE : S_BYPASS;
         end
         S_BYPASS: begin
            if (acc_done) begin
               tmr_load   = 1'b1; // [R04]
               tmr_value  = RST_CYCLES;
               state_next = S_MULT;
            end
         end
         // Linear steps need consecutive state codes
         S_MULT, S_DIV0, S_DIV1, S_DIV2, S_DIV3, S_ALIGN, S_GO, S_BR_ON,
         S_BR_OFF: begin
            if (acc_done) begin
               state_next = state_reg + 5'h01;
            end
         end
         S_RST_WAIT: begin
            if (tmr_expired) begin
               state_next = S_RELEASE; // [R04]
            end
         end
         S_RELEASE: begin
            if (acc_done) begin
               tmr_load   = 1'b1; // [R05]
               tmr_value  = LOCK_CYCLES;
               state_next = S_LOCK_WAIT;
            end
         end
         S_LOCK_WAIT: begin
            if (tmr_expired) begin
               state_next = S_ALIGN; // [R05]
            end
         end
         S_GO_POLL: begin
            if (acc_done && !acc_rdata[`PLLC_STAT_GO_BIT]) begin
               state_next = S_BR_ON; // [R16]
            end
         end
         S_ENABLE: begin
            if (acc_done) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg    <= S_IDLE;
         acc_pend_reg <= 1'b0;
         ref_reg      <= 16'h0000;
         pre_reg      <= 5'h01;
         mult_reg     <= `PLLC_MULT_RESET; // [R07]
         core_reg     <= `PLLC_CORE_DIV_RESET; // [R10]
         peri_reg     <= `PLLC_PERI_DIV_RESET; // [R10]
         mem_reg      <= `PLLC_MEM_DIV_RESET; // [R10]
         done         <= 1'b0;
         cfg_error    <= 1'b0;
         error_code   <= ERR_NONE;
         loop_enabled <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         done      <= 1'b0;
         if (acc_req) begin
            acc_pend_reg <= 1'b1;
         end else if (acc_done) begin
            acc_pend_reg <= 1'b0;
         end
         if (state_reg == S_IDLE && start) begin
            ref_reg   <= cfg_ref_khz; // [R01]
            pre_reg   <= cfg_pre_div;
            mult_reg  <= cfg_mult;
            core_reg  <= cfg_core_div;
            peri_reg  <= cfg_peri_div;
            mem_reg   <= cfg_mem_div;
            cfg_error <= 1'b0;
         end
         if (state_reg == S_CHECK) begin
            error_code <= check_err;
            if (check_err != ERR_NONE) begin
               cfg_error <= 1'b1;
               done      <= 1'b1;
            end
         end
         if (state_reg == S_BYPASS) begin
            loop_enabled <= 1'b0; // [R02]
         end
         if (state_reg == S_ENABLE && acc_done) begin
            loop_enabled <= 1'b1;
            done         <= 1'b1;
         end
      end
   end

   // =======================================================
   // Submodules
   pllc_reg_master u_master (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .ce        (ce),
      .req       (acc_req),
      .req_wr    (acc_wr),
      .req_addr  (acc_addr),
      .req_wdata (acc_wdata),
      .done      (acc_done),
      .rdata     (acc_rdata),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .reg_ack   (reg_ack)
   );

   pllc_wait_timer u_timer (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .ce         (ce),
      .load       (tmr_load),
      .load_value (tmr_value),
      .expired    (tmr_expired)
   );
endmodule // pllc_ctrl

// *** src/pllc_map.vh ***
`ifndef PLLC_MAP_VH
`define PLLC_MAP_VH
// ==========================================================
// Device register addresses and offsets
`define PLLC_BASE_ADDR      32'h4100_0000
`define PLLC_CSR_OFS        32'h0000_0100
`define PLLC_MULT_OFS       32'h0000_0110
`define PLLC_DIV0_OFS       32'h0000_0114
`define PLLC_DIV1_OFS       32'h0000_0118
`define PLLC_DIV2_OFS       32'h0000_011c
`define PLLC_DIV3_OFS       32'h0000_0120
`define PLLC_CMD_OFS        32'h0000_0138
`define PLLC_STAT_OFS       32'h0000_013c
`define PLLC_ALIGN_OFS      32'h0000_0140
`define PLLC_BRIDGE_ADDR    32'h4000_0024
// ==========================================================
// Field positions and values
`define PLLC_CSR_EN_BIT     0
`define PLLC_CSR_RST_BIT    3
`define PLLC_DIV_EN_BIT     15
`define PLLC_CMD_GO_BIT     0
`define PLLC_STAT_GO_BIT    0
`define PLLC_BRIDGE_RST_BIT 0
`define PLLC_ALIGN_ALL      32'h0000_0007
`define PLLC_MULT_RESET     5'h0d
`define PLLC_MULT_MIN       5'h04
`define PLLC_MULT_MAX       5'h19
`define PLLC_CORE_DIV_RESET 5'h01
`define PLLC_PERI_DIV_RESET 5'h02
`define PLLC_MEM_DIV_RESET  5'h03
// ==========================================================
// Frequency limits in kHz
`define PLLC_REF_MIN_KHZ    32'd12000
`define PLLC_REF_MAX_KHZ    32'd50000
`define PLLC_OUT_MIN_KHZ    32'd140000
`define PLLC_OUT_MAX_KHZ    32'd600000
// ==========================================================
// Timing
`define PLLC_CLK_PERIOD_PS  32'd4000
`define PLLC_RST_HOLD_NS    32'd125
`define PLLC_LOCK_TIME_NS   32'd187500
`define PLLC_RST_CYCLES     ((`PLLC_RST_HOLD_NS * 32'd1000 + \
   `PLLC_CLK_PERIOD_PS - 32'd1) / `PLLC_CLK_PERIOD_PS)
`define PLLC_LOCK_CYCLES    ((`PLLC_LOCK_TIME_NS * 32'd1000 + \
   `PLLC_CLK_PERIOD_PS - 32'd1) / `PLLC_CLK_PERIOD_PS)
`endif

// *** src/pllc_reg_master.v ***
// ==========================================================
// Single access master on the device register port
module pllc_reg_master (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        ce,
   input  wire        req,
   input  wire        req_wr,
   input  wire [31:0] req_addr,
   input  wire [31:0] req_wdata,
   output reg         done,
   output reg  [31:0] rdata,
   output reg  [31:0] reg_addr,
   output reg  [31:0] reg_wdata,
   output reg         reg_wr,
   output reg         reg_rd,
   input  wire [31:0] reg_rdata,
   input  wire        reg_ack
);
   reg busy_reg;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         busy_reg  <= 1'b0;
         done      <= 1'b0;
         rdata     <= 32'h0000_0000;
         reg_addr  <= 32'h0000_0000;
         reg_wdata <= 32'h0000_0000;
         reg_wr    <= 1'b0;
         reg_rd    <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (!busy_reg) begin
            if (req) begin
               busy_reg  <= 1'b1;
               reg_addr  <= req_addr;
               reg_wdata <= req_wdata;
               reg_wr    <= req_wr;
               reg_rd    <= !req_wr;
            end
         end else if (reg_ack) begin
            busy_reg <= 1'b0;
            reg_wr   <= 1'b0;
            reg_rd   <= 1'b0;
            done     <= 1'b1;
            if (reg_rd) begin
               rdata <= reg_rdata;
            end
         end
      end
   end
endmodule // pllc_reg_master

// *** src/pllc_wait_timer.v ***
// ==========================================================
// Down counter for sequencing waits
module pllc_wait_timer (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        ce,
   input  wire        load,
   input  wire [31:0] load_value,
   output wire        expired
);
   reg [31:0] count_reg;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_reg <= 32'h0000_0000;
      end else if (ce) begin
         if (load) begin
            count_reg <= load_value;
         end else if (count_reg != 32'h0000_0000) begin
            count_reg <= count_reg - 32'h0000_0001;
         end
      end
   end

   assign expired = (count_reg == 32'h0000_0000) && !load;
endmodule // pllc_wait_timer

// *** tb/pllc_ctrl_sva.sv ***
module pllc_chk #(
   parameter [31:0] LOCK_CYCLES = 32'd46875
) (
   input wire        clk_sys,
   input wire        reset,
   input wire        start,
   input wire        busy,
   input wire        done,
   input wire        cfg_error,
   input wire        loop_enabled,
   input wire [31:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire        reg_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========================================
   // Access history
   wire        wack  = reg_wr && reg_ack;
   wire        csr_w = wack && reg_addr == 32'h4100_0100;
   wire        en_w  = csr_w && reg_wdata[0];
   wire        rst_w = csr_w && reg_wdata[3];
   wire        rel_w = csr_w && reg_wdata == 32'h0;
   wire        div_w = wack && (reg_addr == 32'h4100_0118 ||
                       reg_addr == 32'h4100_011c || reg_addr == 32'h4100_0120);
   wire        go_w  = wack && reg_addr == 32'h4100_0138 && reg_wdata[0];
   wire        lk_w  = wack && (reg_addr == 32'h4100_0110 ||
                       reg_addr == 32'h4100_0114);
   reg  [31:0] hold_reg;
   reg  [31:0] lock_reg;
   reg         go_due_reg;
   reg         align_reg;
   reg         bridge_reg;
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hold_reg   <= 32'h0;
         lock_reg   <= 32'h0;
         go_due_reg <= 1'b0;
         align_reg  <= 1'b0;
         bridge_reg <= 1'b0;
      end else begin
         hold_reg   <= rst_w ? 32'h0 : hold_reg + 32'h1;
         lock_reg   <= (rel_w || lk_w) ? 32'h0 : lock_reg + 32'h1;
         go_due_reg <= div_w | (go_due_reg & ~go_w);
         align_reg  <= align_reg | (wack && reg_addr == 32'h4100_0140 &&
                       reg_wdata[2:0] == 3'h7);
         bridge_reg <= (bridge_reg & ~rst_w) | (wack &&
                       reg_addr == 32'h4000_0024 && reg_wdata[0]);
      end
   end
   // ========================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_strobe_hold: assert property ((reg_wr || reg_rd) && !reg_ack |=>
      $stable({reg_wr, reg_rd, reg_addr, reg_wdata})) else $error("hold");
   a_strobe_drop: assert property ((reg_wr || reg_rd) && reg_ack |=>
      !reg_wr && !reg_rd) else $error("drop");
   a_done_pulse: assert property (done |=> !done) else $error("pulse");
   a_error_early: assert property (done && cfg_error |->
      $past(start && !busy, 2)) else $error("refusal timing");
   a_error_quiet: assert property (cfg_error |-> !reg_wr && !reg_rd)
      else $error("access after refusal");
   a_enable_ack: assert property (en_w |-> ##2 loop_enabled && done)
      else $error("enable");
   a_reset_hold: assert property (rel_w |-> hold_reg >= 32'd31)
      else $error("reset hold");
   a_lock_wait: assert property (en_w |->
      lock_reg >= LOCK_CYCLES - 32'd1) else $error("lock wait");
   a_mult_range: assert property (
      reg_wr && reg_addr == 32'h4100_0110 |->
      reg_wdata[4:0] inside {[5'h3:5'h18]}) else $error("multiplier");
   a_align_go: assert property (go_w |-> align_reg)
      else $error("align");
   a_go_before_en: assert property (en_w |-> !go_due_reg)
      else $error("go");
   a_bridge_en: assert property (en_w |-> bridge_reg)
      else $error("bridge");
endmodule // pllc_chk

bind pllc_ctrl pllc_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_pllc_chk (
   .clk_sys(clk_sys), .reset(reset), .start(start), .busy(busy),
   .done(done), .cfg_error(cfg_error), .loop_enabled(loop_enabled),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_ack(reg_ack));

// *** tb/pllc_dev_model.sv ***
module pllc_dev_model (
   input  wire         clk_sys,
   input  wire         reset,
   input  wire  [3:0]  ack_lat,
   input  wire  [3:0]  go_reads,
   input  wire  [31:0] reg_addr,
   input  wire  [31:0] reg_wdata,
   input  wire         reg_wr,
   input  wire         reg_rd,
   output logic [31:0] reg_rdata,
   output logic        reg_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] csr;
   logic [31:0] mult;
   logic [31:0] div [4];
   logic [31:0] act [4];
   logic [3:0]  wait_cnt;
   logic [3:0]  busy_cnt;
   logic [63:0] wlog [$];
   // ========================================
   // Register port
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         csr       <= 32'h0;         // Loop bypassed
         mult      <= 32'hc;         // Times 13
         wait_cnt  <= 4'h0;
         busy_cnt  <= 4'h0;
         reg_ack   <= 1'b0;
         reg_rdata <= 32'h0;
         for (int i = 0; i < 4; i++) begin
            div[i] <= 32'h8000 + ((i > 1) ? i - 1 : 0);
            act[i] <= 32'h8000 + ((i > 1) ? i - 1 : 0);
         end
      end else if ((reg_wr || reg_rd) && !reg_ack) begin
         wait_cnt <= wait_cnt + 4'h1;
         if (wait_cnt == ack_lat) begin
            wait_cnt  <= 4'h0;
            reg_ack   <= 1'b1;
            reg_rdata <= {31'h0, busy_cnt != 4'h0};
         end
      end else begin
         reg_ack   <= 1'b0;
         reg_rdata <= ~reg_rdata;    // Released bus inverts its last value every cycle
         if (reg_ack && reg_rd && busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
         end
         if (reg_ack && reg_wr) begin
            wlog.push_back({reg_addr, reg_wdata});
            case (reg_addr)
               32'h4100_0100: csr <= reg_wdata; // Bit 0 picks loop
               32'h4100_0110: mult <= reg_wdata;
               32'h4100_0114, 32'h4100_0118, 32'h4100_011c, 32'h4100_0120:
                  div[reg_addr[3:2] - 2'h1] <= reg_wdata;
               32'h4100_0138: if (reg_wdata[0]) begin
                  act      <= div;   // Ratios load together
                  busy_cnt <= go_reads;
               end
               default: ;
            endcase
         end
      end
   end
endmodule // pllc_dev_model

// *** tb/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        start = 1'b0;
   logic [15:0] cfg_ref_khz = 16'h0;
   logic [4:0]  cfg_pre_div = 5'h0;
   logic [4:0]  cfg_mult = 5'h0;
   logic [4:0]  cfg_core_div = 5'h0;
   logic [4:0]  cfg_peri_div = 5'h0;
   logic [4:0]  cfg_mem_div = 5'h0;
   logic [3:0]  ack_lat = 4'h0;
   logic [3:0]  go_reads = 4'h0;
   logic        en_exp = 1'b0;
   wire         busy, done, cfg_error, loop_enabled;
   wire  [2:0]  error_code;
   wire         reg_wr, reg_rd, reg_ack;
   wire  [31:0] reg_addr, reg_wdata, reg_rdata;
   int          err_total = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          tbl [16][6] = '{'{25000,1,20,1,2,3}, '{12000,1,12,1,2,3},
      '{50000,1,12,1,3,3}, '{48000,4,25,2,8,1}, '{40000,1,4,3,6,2},
      '{11999,1,13,1,2,3}, '{50001,1,4,1,2,3}, '{12000,1,11,1,2,3},
      '{50000,1,13,1,2,3}, '{25000,1,3,1,2,3}, '{25000,1,26,1,2,3},
      '{25000,1,20,2,3,3}, '{25000,1,20,1,5,3}, '{25000,0,20,1,2,3},
      '{25000,1,30,1,2,0}, '{5000,1,30,1,2,3}};

   always #2 clk_sys = ~clk_sys;

   pllc_ctrl #(.LOCK_CYCLES(32'd20)) u_pllc_ctrl (
      .clk_sys(clk_sys), .reset(reset), .ce(1'b1), .start(start),
      .cfg_ref_khz(cfg_ref_khz), .cfg_pre_div(cfg_pre_div),
      .cfg_mult(cfg_mult), .cfg_core_div(cfg_core_div),
      .cfg_peri_div(cfg_peri_div), .cfg_mem_div(cfg_mem_div), .busy(busy),
      .done(done), .cfg_error(cfg_error), .error_code(error_code),
      .loop_enabled(loop_enabled), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack));
   pllc_dev_model u_pllc_dev_model (
      .clk_sys(clk_sys), .reset(reset), .ack_lat(ack_lat),
      .go_reads(go_reads), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack));

   // ========================================
   // Checks and reference
   task automatic check(input string what, input logic [63:0] exp,
                        input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   function automatic int exp_code(int r, p, m, c, q, e);
      if (p == 0 || c == 0 || q == 0 || e == 0) return 5;
      if (m < 4 || m > 25) return 1;
      if (r < 12000 * p || r > 50000 * p) return 2;
      if (r * m < 140000 * p || r * m > 600000 * p) return 3;
      if (q != 2 * c && q != 3 * c && q != 4 * c) return 4;
      return 0;
   endfunction

   // ========================================
   // One configuration run
   task automatic run(input int r, p, m, c, q, e);
      int          code;
      int          n;
      logic [63:0] x [$];
      @(negedge clk_sys);
      code = exp_code(r, p, m, c, q, e);
      u_pllc_dev_model.wlog.delete();
      ack_lat = 4'($urandom_range(4));
      go_reads = 4'($urandom_range(3));
      cfg_ref_khz = 16'(r);
      {cfg_pre_div, cfg_mult, cfg_core_div, cfg_peri_div, cfg_mem_div} =
         {5'(p), 5'(m), 5'(c), 5'(q), 5'(e)};
      start = 1'b1;
      @(negedge clk_sys);
      cfg_mult = 5'h0;
      n = 1;
      check("busy", 1, busy);
      while (done !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         start = 1'b0;
         n++;
      end
      check("done", 1, done);
      if (code != 0) check("refusal cycles", 2, n);
      check("cfg_error", code != 0, cfg_error);
      check("error_code", code, error_code);
      if (code == 0) begin
         en_exp = 1'b1;
         x = '{{32'h4100_0100, 32'h8}, {32'h4100_0110, 32'(m - 1)},
            {32'h4100_0114, 32'(32'h8000 + p - 1)},
            {32'h4100_0118, 32'(32'h8000 + c - 1)},
            {32'h4100_011c, 32'(32'h8000 + q - 1)},
            {32'h4100_0120, 32'(32'h8000 + e - 1)},
            {32'h4100_0100, 32'h0}, {32'h4100_0140, 32'h7},
            {32'h4100_0138, 32'h1}, {32'h4000_0024, 32'h1},
            {32'h4000_0024, 32'h0}, {32'h4100_0100, 32'h1}};
         check("core ratio", x[3][31:0], u_pllc_dev_model.act[1]);
         check("mem ratio", x[5][31:0], u_pllc_dev_model.act[3]);
      end
      check("loop_enabled", en_exp, loop_enabled);
      check("writes", x.size(), u_pllc_dev_model.wlog.size());
      foreach (x[i]) check("write", x[i], u_pllc_dev_model.wlog[i]);
   endtask

   // ========================================
   // Main sequence
   initial begin
      void'($urandom(32'he7f6ca33));
      repeat (6) @(negedge clk_sys);
      reset = 1'b0;
      check("idle", 0,
            {busy, done, cfg_error, error_code, loop_enabled});
      check("mult default", 32'hc, u_pllc_dev_model.mult);
      check("div defaults", 48'h8000_8001_8002,
            {u_pllc_dev_model.act[1][15:0], u_pllc_dev_model.act[2][15:0],
             u_pllc_dev_model.act[3][15:0]});
      foreach (tbl[i]) run(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3],
                           tbl[i][4], tbl[i][5]);
      repeat (30) run($urandom_range(60000, 9000), $urandom_range(4),
                      $urandom_range(27, 2), $urandom_range(3),
                      $urandom_range(12), $urandom_range(3));
      end_of_test();
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         end_of_test();
      end
   end
endmodule // tb_top
